// ### ddc_iic_slave_port_bench.sv
// self-checking bench: apb master, two iic hosts, vsync pulses
// assumes dis_slave_port and dis_host_model; sda wires pulled up here
`timescale 1ns/1ps
`include "dis_consts.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module ddc_iic_slave_port_bench;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, vsync, irq, perr, ack;
  logic a_oe, a_o, d_oe, d_o, a_scl, d_scl, a_low, d_low;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [7:0] dat, rx;
  logic [2:0] acks;
  int failures = 0;
  int n_checks = 0;
  int seed = 32'h605F5046;
  // open-drain wires with pull-up
  wire a_sda = ~(a_low | a_oe);
  wire d_sda = ~(d_low | d_oe);
  dis_slave_port #(.IDLE_VS(4)) i_dut (.I_MCLK(clk), .I_SYS_RST(rst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_A_SCL(a_scl),
    .I_A_SDA(a_sda), .O_A_SDA_O(a_o), .O_A_SDA_OE(a_oe), .I_D_SCL(d_scl),
    .I_D_SDA(d_sda), .O_D_SDA_O(d_o), .O_D_SDA_OE(d_oe), .I_VSYNC(vsync), .O_IRQ(irq));
  dis_host_model i_ah (.o_scl(a_scl), .o_sda_low(a_low), .i_sda(a_sda));
  dis_host_model i_dh (.o_scl(d_scl), .o_sda_low(d_low), .i_sda(d_sda));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // counts, verdict and end of run
  task give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one apb transfer; bounded wait for pready
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      give_verdict();
    end
    v = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // vsync rising edges, slow against the clock
  task automatic vs(input int cnt);
    repeat (cnt) begin
      @(posedge clk) vsync <= 1'b1;
      repeat (4) @(posedge clk);
      vsync <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, vsync} = 4'h0;
    paddr = 18'h00000;
    pwdata = 32'h00000000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(0, `DIS_IDX_SLAVE, 8'h00);
    `CHK(v[7:0], {`DIS_OWN_ADDR_RST, 1'b0})
    apb(0, `DIS_IDX_IEN, 8'h00);
    `CHK(v[7:0], 8'h00)
    apb(0, 16'hFF2E, 8'h00);
    `CHK(perr, 1'b1)
    apb(1, `DIS_IDX_IEN, 8'hFF);
    // matched write frame on the analog channel
    dat = 8'($random(seed));
    i_ah.wframe(8'h4A, 8'h5A, dat, acks);
    `CHK(acks, 3'b000)
    apb(0, `DIS_IDX_FLG, 8'h00);
    `CHK(v[7:0], 8'h97)
    `CHK(irq, 1'b1)
    apb(0, `DIS_IDX_SUB, 8'h00);
    `CHK(v[7:0], 8'h5A)
    apb(0, `DIS_IDX_RX, 8'h00);
    `CHK(v[7:0], dat)
    apb(0, `DIS_IDX_FLG, 8'h00);
    `CHK(v[7:0], 8'h93)
    // masked flags keep the interrupt low
    apb(1, `DIS_IDX_IEN, 8'h00);
    apb(0, `DIS_IDX_FLG, 8'h00);
    `CHK(irq, 1'b0)
    apb(1, `DIS_IDX_IEN, 8'hFF);
    apb(1, `DIS_IDX_FLG, 8'h00);
    apb(0, `DIS_IDX_FLG, 8'h00);
    `CHK(v[7:0], 8'h00)
    `CHK(irq, 1'b0)
    // foreign address: no ack, only the write-stop flag
    i_ah.wframe(8'h50, 8'h11, 8'h22, acks);
    `CHK(acks, 3'b111)
    apb(0, `DIS_IDX_FLG, 8'h00);
    `CHK(v[7:0], 8'h80)
    apb(1, `DIS_IDX_FLG, 8'h00);
    // digital channel while analog is selected
    i_dh.wframe(8'h4A, 8'h11, 8'h22, acks);
    `CHK(acks, 3'b111)
    apb(0, `DIS_IDX_FLG, 8'h00);
    `CHK(v[7:0], 8'h40)
    apb(1, `DIS_IDX_FLG, 8'h00);
    // host read on the digital channel
    dat = 8'($random(seed));
    apb(1, `DIS_IDX_TX, dat);
    apb(1, `DIS_IDX_SLAVE, 8'h4B);
    i_dh.rframe(8'h4B, rx, ack);
    `CHK(ack, 1'b0)
    `CHK(rx, dat)
    `CHK({a_o, d_o}, 2'b00)
    apb(0, `DIS_IDX_FLG, 8'h00);
    `CHK(v[7:0], 8'h19)
    apb(0, `DIS_IDX_TX, 8'h00);
    `CHK(v[7:0], 8'h00)
    apb(1, `DIS_IDX_TX, dat);
    apb(1, `DIS_IDX_FLG, 8'h00);
    apb(0, `DIS_IDX_FLG, 8'h00);
    `CHK(v[7:0], 8'h00)
    // idle timeout after the parameterised vsync count
    apb(1, `DIS_IDX_CTL, 8'h01);
    vs(3);
    apb(0, `DIS_IDX_FLG, 8'h00);
    `CHK(v[7:0], 8'h00)
    vs(1);
    apb(0, `DIS_IDX_FLG, 8'h00);
    `CHK(v[7:0], 8'h20)
    give_verdict();
  end
endmodule

// ### dis_consts.svh
// register indices, field positions and reset values of the ddc iic slave port
// assumes inclusion by bare name from the bench and the port module
`ifndef DIS_CONSTS_SVH
`define DIS_CONSTS_SVH
// register indices; byte address is four times the index
`define DIS_IDX_SLAVE 16'hFF27
`define DIS_IDX_SUB 16'hFF28
`define DIS_IDX_RX 16'hFF29
`define DIS_IDX_TX 16'hFF2A
`define DIS_IDX_FLG 16'hFF2B
`define DIS_IDX_IEN 16'hFF2C
`define DIS_IDX_CTL 16'hFF2D
// reset values
`define DIS_OWN_ADDR_RST 7'h25
`define DIS_BYTE_RST 8'h00
// event flag bit positions
`define DIS_F_SLV 0
`define DIS_F_SUB 1
`define DIS_F_RX 2
`define DIS_F_TX 3
`define DIS_F_STOP 4
`define DIS_F_IDLE 5
`define DIS_F_DWR 6
`define DIS_F_AWR 7
// flags that software clears by writing zero
`define DIS_W0C_MASK 8'hF3
// link control bits
`define DIS_C_DDC2 0
`define DIS_C_VSR 1
// bit counts within a byte
`define DIS_BYTE_BITS 4'h8
`define DIS_RW_POS 4'h7
`endif

// ### dis_host_model.sv
// behavioural iic host that drives one ddc pin pair from bench tasks
// assumes an 80 ns bit period and a pull-up resolving the data wire outside
`timescale 1ns/1ps
module dis_host_model (
  // pins
  output logic o_scl,
  output logic o_sda_low,
  input wire logic i_sda
);
  // idle bus: clock stands high and data is released between frames
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // start condition, half a clock off the edge so pins never race it
  task automatic start();
    #5 o_sda_low = 1'b1;
    #40;
  endtask
  task automatic stop();
    o_scl = 1'b0;
    #10 o_sda_low = 1'b1;
    #30 o_scl = 1'b1;
    #40 o_sda_low = 1'b0;
    #80;
  endtask
  // one bit; data sampled late in the high phase so slave ack has settled
  task automatic bit_io(input logic b, output logic r);
    o_scl = 1'b0;
    #10 o_sda_low = ~b;
    #30 o_scl = 1'b1;
    #38 r = i_sda;
    #2;
  endtask
  // msb first, one ack bit after each byte
  task automatic byte_io(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
                         output logic k);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ab, k);
  endtask
  task automatic wframe(input logic [7:0] ad, sb, dt, output logic [2:0] k);
    logic [7:0] r;
    start();
    byte_io(ad, 1'b1, r, k[0]);
    byte_io(sb, 1'b1, r, k[1]);
    byte_io(dt, 1'b1, r, k[2]);
    stop();
  endtask
  // read one byte and end it with a host nack
  task automatic rframe(input logic [7:0] ad, output logic [7:0] d, output logic k);
    logic [7:0] r;
    start();
    byte_io(ad, 1'b1, r, k);
    byte_io(8'hFF, 1'b1, d, r[0]);
    stop();
  endtask
endmodule

// ### dis_pkg.sv
// types shared by the ddc iic slave port
// assumes dis_consts.svh sits in the same folder
package dis_pkg;
  // byte phase of the selected channel, gray along idle-addr-sub-data
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_SUB = 3'h3,
    ST_WDATA = 3'h2,
    ST_RDATA = 3'h6
  } dis_state_t;
endpackage

// ### dis_slave_port.sv
// ddc iic slave port: apb registers, two ddc pin pairs, one interrupt
// assumes apb master on I_MCLK; pins asynchronous; open-drain resolved outside
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "dis_consts.svh"

//Contract
//- Addresses match a programmable 7-bit own address; a select bit picks the channel.
//- A latched matching address sets flag bit 0, cleared by writing zero.
//- The received sub-address is captured read-only and sets flag bit 1, cleared by writing zero.
//- A received data byte is captured read-only and sets flag bit 2, cleared by reading it.
//- A write-only transmit byte is shifted out to the host during reads.
//- Loading the shifter from the transmit byte sets flag bit 3, cleared by writing that byte.
//- A stop ending a matched transfer sets flag bit 4, cleared by writing zero.
//- A stop in write mode on the analog channel sets flag bit 7, cleared by writing zero.
//- A stop in write mode on the digital channel sets flag bit 6, cleared by writing zero.
//- In ddc2 transition mode a clock line idle for 128 vertical syncs sets flag bit 5.
//- Each flag has an enable at the same position, all enables reset to zero.
//- The vertical sync count watches the analog channel when routing is 0, the digital when 1.
module dis_slave_port #(
  parameter int ADDR_W = 18,
  parameter int IDLE_VS = 128
) (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // analog ddc pins
  input wire logic I_A_SCL,
  input wire logic I_A_SDA,
  output logic O_A_SDA_O,
  output logic O_A_SDA_OE,
  // digital ddc pins
  input wire logic I_D_SCL,
  input wire logic I_D_SDA,
  output logic O_D_SDA_O,
  output logic O_D_SDA_OE,
  // vertical sync and interrupt
  input wire logic I_VSYNC,
  output logic O_IRQ
);
  logic [1:0] scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
  logic [1:0] scl_rise, scl_fall, start_c, stop_c, wstop;
  logic [3:0] wcnt [2];
  logic [1:0] wmode;
  logic [2:0] vs_p;
  logic vs_rise;
  logic [7:0] vs_cnt;
  logic [6:0] own_addr;
  logic chan_sel;
  logic [7:0] ien, next_ien, ctl, tx_byte, sub_reg, rx_reg, flags, next_flags, clr, ev;
  dis_pkg::dis_state_t st;
  logic [3:0] bitcnt;
  logic [7:0] sh, txs;
  logic ack_phase, drive, rw, matched, mnack;
  logic s_rise, s_fall, s_sda, s_start, s_stop, byte_done, r_edge;
  logic [15:0] idx;
  logic acc, wr, rd, hit;
  logic [7:0] rdata;
  wire [1:0] scl_pin = {I_D_SCL, I_A_SCL};
  wire [1:0] sda_pin = {I_D_SDA, I_A_SDA};

  // per channel: two-stage sync, edge, start/stop and write-mode tracking
  for (genvar c = 0; c < 2; c++) begin : g_ch
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
        {scl_m[c], scl_s[c], scl_q[c], sda_m[c], sda_s[c], sda_q[c]} <= 6'h3F;
      end else begin
        {scl_q[c], scl_s[c], scl_m[c]} <= {scl_s[c], scl_m[c], scl_pin[c]};
        {sda_q[c], sda_s[c], sda_m[c]} <= {sda_s[c], sda_m[c], sda_pin[c]};
      end
    end
    assign scl_rise[c] = scl_s[c] & ~scl_q[c];
    assign scl_fall[c] = ~scl_s[c] & scl_q[c];
    assign start_c[c] = scl_s[c] & scl_q[c] & sda_q[c] & ~sda_s[c];
    assign stop_c[c] = scl_s[c] & scl_q[c] & ~sda_q[c] & sda_s[c];
    assign wstop[c] = stop_c[c] & wmode[c];
    // direction bit is the eighth bit after start, low means write
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
        {wcnt[c], wmode[c]} <= 5'h00;
      end else if (start_c[c]) begin
        {wcnt[c], wmode[c]} <= 5'h00;
      end else if (stop_c[c]) begin
        wmode[c] <= 1'h0;
      end else if (scl_rise[c] && wcnt[c] < `DIS_BYTE_BITS) begin
        wcnt[c] <= wcnt[c] + 4'h1;
        if (wcnt[c] == `DIS_RW_POS) begin
          wmode[c] <= ~sda_s[c];
        end
      end
    end
  end

  assign s_rise = scl_rise[chan_sel];
  assign s_fall = scl_fall[chan_sel];
  assign s_sda = sda_s[chan_sel];
  assign s_start = start_c[chan_sel];
  assign s_stop = stop_c[chan_sel];
  assign byte_done = s_fall & ~ack_phase & (bitcnt == `DIS_BYTE_BITS);
  // vertical sync sync and edge
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      vs_p <= 3'h0;
    end else begin
      vs_p <= {vs_p[1:0], I_VSYNC};
    end
  end
  assign vs_rise = vs_p[1] & ~vs_p[2];
  // routing picks whose clock line counts as idle
  assign r_edge = scl_rise[ctl[`DIS_C_VSR]] | scl_fall[ctl[`DIS_C_VSR]];
  // idle count saturates so the flag fires once per idle spell
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      vs_cnt <= 8'h00;
    end else if (!ctl[`DIS_C_DDC2] || r_edge) begin
      vs_cnt <= 8'h00;
    end else if (vs_rise && vs_cnt != 8'(IDLE_VS)) begin
      vs_cnt <= vs_cnt + 8'h01;
    end
  end
  // events of this cycle
  always_comb begin
    ev = 8'h00;
    ev[`DIS_F_SLV] = byte_done & (st == dis_pkg::ST_ADDR) & (sh[7:1] == own_addr);
    ev[`DIS_F_SUB] = byte_done & (st == dis_pkg::ST_SUB);
    ev[`DIS_F_RX] = byte_done & (st == dis_pkg::ST_WDATA);
    // transmit byte moves to the shifter
    ev[`DIS_F_TX] = s_fall & ack_phase & ((st == dis_pkg::ST_ADDR) & rw
      | (st == dis_pkg::ST_RDATA) & ~mnack);
    ev[`DIS_F_STOP] = s_stop & matched;
    ev[`DIS_F_IDLE] = ctl[`DIS_C_DDC2] & ~r_edge & vs_rise
      & (vs_cnt == 8'(IDLE_VS - 1));
    ev[`DIS_F_DWR] = wstop[1];
    ev[`DIS_F_AWR] = wstop[0];
  end
  // byte engine of the selected channel
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      st <= dis_pkg::ST_IDLE;
      bitcnt <= 4'h0;
      {sh, txs, sub_reg, rx_reg} <= {4{`DIS_BYTE_RST}};
      {ack_phase, drive, rw, matched, mnack} <= 5'h00;
    end else if (s_start) begin
      st <= dis_pkg::ST_ADDR;
      bitcnt <= 4'h0;
      {ack_phase, drive, matched} <= 3'h0;
    end else if (s_stop) begin
      st <= dis_pkg::ST_IDLE;
      {drive, matched} <= 2'h0;
    end else if (st != dis_pkg::ST_IDLE) begin
      if (s_rise && ack_phase) begin
        mnack <= s_sda;
      end else if (s_rise) begin
        sh <= {sh[6:0], s_sda};
        bitcnt <= bitcnt + 4'h1;
      end
      if (byte_done) begin
        ack_phase <= 1'h1;
        bitcnt <= 4'h0;
        case (st)
          dis_pkg::ST_ADDR: begin
            // acknowledge only our own address, else let go
            if (sh[7:1] == own_addr) begin
              matched <= 1'h1;
              rw <= sh[0];
              drive <= 1'h1;
            end else begin
              st <= dis_pkg::ST_IDLE;
              drive <= 1'h0;
            end
          end
          dis_pkg::ST_SUB: begin
            sub_reg <= sh;
            drive <= 1'h1;
          end
          dis_pkg::ST_WDATA: begin
            rx_reg <= sh;
            drive <= 1'h1;
          end
          default: drive <= 1'h0;
        endcase
      end else if (s_fall && ack_phase) begin
        ack_phase <= 1'h0;
        case (st)
          dis_pkg::ST_ADDR: begin
            st <= rw ? dis_pkg::ST_RDATA : dis_pkg::ST_SUB;
            txs <= tx_byte;
            drive <= rw & ~tx_byte[7];
          end
          dis_pkg::ST_SUB: begin
            st <= dis_pkg::ST_WDATA;
            drive <= 1'h0;
          end
          dis_pkg::ST_RDATA: begin
            // reload always; keep reading unless the host refused the last byte
            st <= mnack ? dis_pkg::ST_IDLE : dis_pkg::ST_RDATA;
            txs <= tx_byte;
            drive <= ~mnack & ~tx_byte[7];
          end
          default: drive <= 1'h0;
        endcase
      end else if (s_fall && st == dis_pkg::ST_RDATA) begin
        // shift next bit out, a zero pulls the line low
        txs <= {txs[6:0], 1'h0};
        drive <= ~txs[6];
      end
    end
  end

  // apb decode; one wait state, answer registered
  assign idx = 16'(I_PADDR >> 2);
  assign acc = I_PSEL & I_PENABLE;
  assign wr = acc & O_PREADY & I_PWRITE;
  assign rd = acc & O_PREADY & ~I_PWRITE;
  always_comb begin
    hit = 1'h1;
    case (idx)
      `DIS_IDX_SLAVE: rdata = {own_addr, chan_sel};
      `DIS_IDX_SUB: rdata = sub_reg;
      `DIS_IDX_RX: rdata = rx_reg;
      `DIS_IDX_FLG: rdata = flags;
      `DIS_IDX_IEN: rdata = ien;
      `DIS_IDX_CTL: rdata = ctl;
      `DIS_IDX_TX: rdata = 8'h00;
      default: begin
        rdata = 8'h00;
        hit = 1'h0;
      end
    endcase
  end
  // apb answer flops
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      {O_PREADY, O_PSLVERR} <= 2'h0;
      O_PRDATA <= 32'h0000_0000;
    end else begin
      O_PREADY <= acc & ~O_PREADY;
      O_PSLVERR <= acc & ~O_PREADY & ~hit;
      if (acc && !O_PREADY) begin
        O_PRDATA <= {24'h00_0000, rdata};
      end
    end
  end

  // software-written registers; writes land at the completing edge
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      {own_addr, chan_sel} <= {`DIS_OWN_ADDR_RST, 1'h0};
      {ien, ctl, tx_byte} <= {3{`DIS_BYTE_RST}};
    end else if (wr) begin
      case (idx)
        `DIS_IDX_SLAVE: {own_addr, chan_sel} <= I_PWDATA[7:0];
        `DIS_IDX_IEN: ien <= I_PWDATA[7:0];
        `DIS_IDX_CTL: ctl <= I_PWDATA[7:0];
        `DIS_IDX_TX: tx_byte <= I_PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // flags: set wins over every kind of clear
  always_comb begin
    clr = 8'h00;
    if (wr && idx == `DIS_IDX_FLG) begin
      clr = ~I_PWDATA[7:0] & `DIS_W0C_MASK;
    end
    // reading the data byte clears its flag
    clr[`DIS_F_RX] = rd & (idx == `DIS_IDX_RX);
    // writing the transmit byte clears its flag
    clr[`DIS_F_TX] = wr & (idx == `DIS_IDX_TX);
    next_flags = (flags & ~clr) | ev;
    next_ien = (wr && idx == `DIS_IDX_IEN) ? I_PWDATA[7:0] : ien;
  end

  // flag, interrupt and pin-drive flops
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      flags <= 8'h00;
      {O_IRQ, O_A_SDA_OE, O_D_SDA_OE, O_A_SDA_O, O_D_SDA_O} <= 5'h00;
    end else begin
      flags <= next_flags;
      // or of enabled flags; enables as written this cycle, so no lag
      O_IRQ <= |(next_flags & next_ien);
      // only the selected channel is ever pulled low
      O_A_SDA_OE <= drive & ~chan_sel;
      O_D_SDA_OE <= drive & chan_sel;
      {O_A_SDA_O, O_D_SDA_O} <= 2'h0;
    end
  end

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST);
  chk_slv_flag: assert property (ev[0] |=> flags[0])
    else $error("address flag not set");
  chk_sub_capture: assert property (ev[1] |=> flags[1] && sub_reg == $past(sh))
    else $error("sub-address not captured");
  chk_rx_clear: assert property (rd && idx == `DIS_IDX_RX && !ev[2] |=> !flags[2])
    else $error("data flag survived read");
  chk_tx_clear: assert property (wr && idx == `DIS_IDX_TX && !ev[3] |=> !flags[3])
    else $error("transmit flag survived write");
  chk_stop_match: assert property (ev[4] |=> flags[4] && !matched)
    else $error("stop flag without match");
  chk_idle_mode: assert property (ev[5] |-> ctl[0] && vs_cnt == 8'(IDLE_VS - 1))
    else $error("idle flag outside mode");
  chk_irq_or: assert property (O_IRQ == |(flags & ien))
    else $error("interrupt not or of flags");
  chk_release_idle: assert property (
    (st == dis_pkg::ST_IDLE)[*3] |-> !O_A_SDA_OE && !O_D_SDA_OE)
    else $error("data line held while idle");
  chk_wr_stop: assert property (wstop[0] |=> flags[7])
    else $error("analog write stop lost");
  chk_apb_wait: assert property (acc && !O_PREADY |=> O_PREADY ##1 !O_PREADY)
    else $error("apb answer timing");
  cov_addr: cover property (ev[0] ##[1:1000] ev[1]);
  cov_read: cover property (ev[3] ##[1:1000] ev[4]);
  cov_irq: cover property ($rose(O_IRQ));
endmodule
